// ### src/rrc_pkg.sv
/*
 * Constants shared by the refresh and range configuration block:
 * command codes, register pointers, field layout and reset values.
 * Assumes a byte-wide two-wire command interface in front of the block.
 */
package rrc_pkg;
   // Command code of the refresh sent through the bus general call
   localparam logic [7:0] CMD_GC_REFRESH = 8'h1E;
   // Pointer value that selects the range configuration register
   localparam logic [7:0] REG_RANGE_CFG = 8'h20;
   // Seven-bit address of the bus general call
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
   // Range configuration value after reset: every field unipolar
   localparam logic [15:0] RANGE_CFG_RESET = 16'h0000;
   localparam logic [1:0] RANGE_UNIPOLAR = 2'h0;
   localparam logic [1:0] RANGE_BIPOLAR = 2'h1;
   // Field layout: 2-bit fields, channel 1 in the highest pair of each byte
   localparam int FIELD_W = 2;
   localparam int SENSE_FIELD_BASE = 8;
   localparam int BUS_FIELD_BASE = 0;
   // Bits in one transferred byte, and width of the bit counter
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Least wait before results may be read after a refresh
   localparam int REFRESH_SETTLE_US = 1000;
   localparam int CLK_MHZ = 50;
   localparam int REFRESH_SETTLE_CYC = REFRESH_SETTLE_US * CLK_MHZ;
   // Flop values after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] CNT_RESET = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_WDATA,
      ST_ACK,
      ST_RDATA,
      ST_RACK
   } rrc_state_t;
endpackage

// ### src/rrc_bank_if.sv
/*
 * Signals between the serial front end and the result bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rrc_bank_if;
   logic refresh;          // One-cycle refresh request
   logic cfg_we;           // One-cycle range configuration write
   logic [15:0] cfg_wdata; // Data for the configuration write
   logic [15:0] cfg_q;     // Current range configuration
   logic slow_rise;        // Slow pin went low to high
   logic slow_fall;        // Slow pin went high to low

   modport front (output refresh, output cfg_we, output cfg_wdata, input cfg_q,
      output slow_rise, output slow_fall);
   modport bank (input refresh, input cfg_we, input cfg_wdata, output cfg_q,
      input slow_rise, input slow_fall);
endinterface

// ### src/rrc_result_bank.sv
/*
 * Result bank: readable copies of the measurement results, the clear
 * of the internal accumulators, the range configuration register and
 * the slow pin transition flags.
 * Assumes the accumulator datapath clears itself on the accum_clear pulse.
 */
`timescale 1ns/1ps
module rrc_result_bank #(
   parameter int CH = 4,
   parameter int RES_W = 16,
   parameter int ACC_W = 56,
   parameter int CNT_W = 32
) (
   input wire logic clk,                         // System clock
   input wire logic reset,                       // Asynchronous reset, high
   rrc_bank_if.bank bus,                         // Requests from the front end
   input wire logic [CH*ACC_W-1:0] int_accum,    // Internal accumulators
   input wire logic [CNT_W-1:0] int_accum_count, // Internal accumulator count
   input wire logic [CH*RES_W-1:0] int_bus_voltage,   // Internal bus voltage results
   input wire logic [CH*RES_W-1:0] int_sense_voltage, // Internal sense voltage results
   output logic [CH*ACC_W-1:0] rd_accum,         // Readable accumulators
   output logic [CNT_W-1:0] rd_accum_count,      // Readable accumulator count
   output logic [CH*RES_W-1:0] bus_voltage_result,   // Readable bus voltages
   output logic [CH*RES_W-1:0] sense_voltage_result, // Readable sense voltages
   output logic accum_clear,                     // Clear internal accumulators
   output logic slow_pin_rise_seen,              // Rise latched since refresh
   output logic slow_pin_fall_seen               // Fall latched since refresh
);
   logic [CH*ACC_W-1:0] next_rd_accum;
   logic [CNT_W-1:0] next_rd_accum_count;
   logic [CH*RES_W-1:0] next_bus_voltage;
   logic [CH*RES_W-1:0] next_sense_voltage;
   logic next_accum_clear;
   logic next_rise_seen;
   logic next_fall_seen;
   logic [15:0] cfg;
   logic [15:0] next_cfg;

   assign bus.cfg_q = cfg;

   // Snapshot and clear share one edge; the datapath clears a cycle later,
   // so the copies always hold the values from before the clear
   always_comb begin
      next_rd_accum = rd_accum;
      next_rd_accum_count = rd_accum_count;
      next_bus_voltage = bus_voltage_result;
      next_sense_voltage = sense_voltage_result;
      next_accum_clear = bus.refresh;
      if (bus.refresh) begin
         next_rd_accum = int_accum;
         next_rd_accum_count = int_accum_count;
         next_bus_voltage = int_bus_voltage;
         next_sense_voltage = int_sense_voltage;
      end
      // Set wins over the clear so no transition is lost
      next_rise_seen = bus.slow_rise | (slow_pin_rise_seen & ~bus.refresh);
      next_fall_seen = bus.slow_fall | (slow_pin_fall_seen & ~bus.refresh);
      next_cfg = bus.cfg_we ? bus.cfg_wdata : cfg;
   end

   // Registers of the bank
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_accum <= '0;
         rd_accum_count <= '0;
         bus_voltage_result <= '0;
         sense_voltage_result <= '0;
         accum_clear <= 1'b0;
         slow_pin_rise_seen <= 1'b0;
         slow_pin_fall_seen <= 1'b0;
         cfg <= rrc_pkg::RANGE_CFG_RESET;
      end else begin
         rd_accum <= next_rd_accum;
         rd_accum_count <= next_rd_accum_count;
         bus_voltage_result <= next_bus_voltage;
         sense_voltage_result <= next_sense_voltage;
         accum_clear <= next_accum_clear;
         slow_pin_rise_seen <= next_rise_seen;
         slow_pin_fall_seen <= next_fall_seen;
         cfg <= next_cfg;
      end
   end
endmodule // rrc_result_bank

// ### src/rrc_refresh_range_config.sv
/*
 * Two-wire slave front end of the refresh and range configuration block,
 * with the result bank instantiated below it.
 * Assumes scl, sda and the slow pin are asynchronous and sampled by the
 * 50 MHz clock, well above the serial bit rate; sda is open drain.
 */
`timescale 1ns/1ps
// What this block does
// - General-call refresh is a data-less command byte.
// - Accept general-call refresh like the ordinary refresh.
// - Refresh copies accumulators, count and voltage results.
// - After copying, clear internal accumulators and count.
// - Both refreshes clear slow pin transition flags.
module rrc_refresh_range_config #(
   parameter logic [6:0] DEV_ADDR = 7'h10,    // Own bus address
   parameter logic [7:0] REFRESH_CMD = 8'h00, // Ordinary refresh command
   parameter int CH = 4,
   parameter int RES_W = 16,
   parameter int ACC_W = 56,
   parameter int CNT_W = 32
) (
   input wire logic clk,                         // System clock, 50 MHz
   input wire logic reset,                       // Asynchronous reset, high
   input wire logic scl_in,                      // Serial clock pin level
   input wire logic sda_in,                      // Serial data pin level
   output logic sda_out,                         // Serial data drive value
   output logic sda_oe,                          // High while pulling sda low
   input wire logic slow_pin,                    // Slow control pin level
   input wire logic [CH*ACC_W-1:0] int_accum,    // Internal accumulators
   input wire logic [CNT_W-1:0] int_accum_count, // Internal accumulator count
   input wire logic [CH*RES_W-1:0] int_bus_voltage,   // Internal bus voltages
   input wire logic [CH*RES_W-1:0] int_sense_voltage, // Internal sense voltages
   output logic [CH*ACC_W-1:0] rd_accum,         // Readable accumulators
   output logic [CNT_W-1:0] rd_accum_count,      // Readable accumulator count
   output logic [CH*RES_W-1:0] bus_voltage_result,   // Readable bus voltages
   output logic [CH*RES_W-1:0] sense_voltage_result, // Readable sense voltages
   output logic accum_clear,                     // Clear internal accumulators
   output logic [15:0] range_cfg,                // Range configuration
   output logic slow_pin_rise_seen,              // Slow pin rise latched
   output logic slow_pin_fall_seen               // Slow pin fall latched
);
   if (CH != 4) begin : g_ch_check
      $error("Range register layout serves exactly four channels");
   end

   rrc_bank_if bank_if ();

   // Synchronisers plus one delay stage for edge detection
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;
   logic slow_s1, slow_s2, slow_d;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
         slow_s1 <= 1'b0;
         slow_s2 <= 1'b0;
         slow_d <= 1'b0;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
         slow_s1 <= slow_pin;
         slow_s2 <= slow_s1;
         slow_d <= slow_s2;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign bank_if.slow_rise = slow_s2 & ~slow_d;
   assign bank_if.slow_fall = ~slow_s2 & slow_d;

   // Transfer state
   rrc_pkg::rrc_state_t state, next_state, ack_next, next_ack_next;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic [7:0] ptr, next_ptr;
   logic [7:0] hi_byte, next_hi_byte;
   logic byte_idx, next_byte_idx;
   logic gen_call, next_gen_call;
   logic next_sda_oe;
   logic refresh_q, next_refresh;
   logic cfg_we_q, next_cfg_we;
   logic [15:0] cfg_wdata_q, next_cfg_wdata;
   logic [7:0] rd_byte;

   assign bank_if.refresh = refresh_q;
   assign bank_if.cfg_we = cfg_we_q;
   assign bank_if.cfg_wdata = cfg_wdata_q;
   assign sda_out = 1'b0; // Open drain: only ever pulls low

   // Byte offered on a read; unknown pointers read as zero
   always_comb begin
      rd_byte = rrc_pkg::BYTE_RESET;
      if (ptr == rrc_pkg::REG_RANGE_CFG) begin
         rd_byte = byte_idx ? bank_if.cfg_q[7:0] : bank_if.cfg_q[15:8];
      end
   end

   // Next state of the serial slave; decisions fall on the scl fall
   // that ends a byte, so the ack is already driven before scl rises
   always_comb begin
      next_state = state;
      next_ack_next = ack_next;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_hi_byte = hi_byte;
      next_byte_idx = byte_idx;
      next_gen_call = gen_call;
      next_sda_oe = sda_oe;
      next_refresh = 1'b0;
      next_cfg_we = 1'b0;
      next_cfg_wdata = cfg_wdata_q;
      if (bus_start) begin
         next_state = rrc_pkg::ST_ADDR;
         next_bit_cnt = rrc_pkg::CNT_RESET;
         next_sda_oe = 1'b0;
      end else if (bus_stop) begin
         next_state = rrc_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         unique case (state)
            rrc_pkg::ST_IDLE: begin
               next_sda_oe = 1'b0;
            end
            rrc_pkg::ST_ADDR, rrc_pkg::ST_CMD, rrc_pkg::ST_WDATA: begin
               if (scl_rise && bit_cnt != rrc_pkg::BITS_PER_BYTE) begin
                  next_shreg = {shreg[6:0], sda_s2};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == rrc_pkg::BITS_PER_BYTE) begin
                  next_state = rrc_pkg::ST_ACK;
                  next_sda_oe = 1'b1;
                  if (state == rrc_pkg::ST_ADDR) begin
                     next_byte_idx = 1'b0;
                     next_gen_call = (shreg[7:1] == rrc_pkg::GENERAL_CALL_ADDR) && !shreg[0];
                     next_ack_next = shreg[0] ? rrc_pkg::ST_RDATA : rrc_pkg::ST_CMD;
                     if (shreg[7:1] != DEV_ADDR && !next_gen_call) begin
                        next_state = rrc_pkg::ST_IDLE;
                        next_sda_oe = 1'b0;
                     end
                  end else if (state == rrc_pkg::ST_CMD) begin
                     if (gen_call) begin
                        // Only the refresh is served by general call, and
                        // no data follows it
                        next_ack_next = rrc_pkg::ST_IDLE;
                        next_refresh = (shreg == rrc_pkg::CMD_GC_REFRESH);
                        next_sda_oe = next_refresh;
                        if (!next_refresh) begin
                           next_state = rrc_pkg::ST_IDLE;
                        end
                     end else begin
                        next_ptr = shreg;
                        next_ack_next = rrc_pkg::ST_WDATA;
                        next_refresh = (shreg == rrc_pkg::CMD_GC_REFRESH) || (shreg == REFRESH_CMD);
                     end
                  end else if (ptr == rrc_pkg::REG_RANGE_CFG) begin
                     // High byte first; the register changes after the low byte
                     next_byte_idx = ~byte_idx;
                     next_hi_byte = shreg;
                     next_cfg_we = byte_idx;
                     next_cfg_wdata = {hi_byte, shreg};
                     next_ack_next = rrc_pkg::ST_WDATA;
                  end else begin
                     next_state = rrc_pkg::ST_IDLE;
                     next_sda_oe = 1'b0;
                  end
               end
            end
            rrc_pkg::ST_ACK: begin
               if (scl_fall) begin
                  next_state = ack_next;
                  next_bit_cnt = rrc_pkg::CNT_RESET;
                  next_sda_oe = 1'b0;
                  if (ack_next == rrc_pkg::ST_RDATA) begin
                     next_shreg = rd_byte;
                     next_sda_oe = ~rd_byte[7];
                     next_bit_cnt = 4'h1;
                     next_byte_idx = ~byte_idx;
                  end
               end
            end
            rrc_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt == rrc_pkg::BITS_PER_BYTE) begin
                     next_state = rrc_pkg::ST_RACK;
                     next_sda_oe = 1'b0;
                  end else begin
                     next_sda_oe = ~shreg[6];
                     next_shreg = {shreg[6:0], 1'b0};
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            rrc_pkg::ST_RACK: begin
               // Master ack continues the read, nack ends it
               if (scl_rise) begin
                  next_ack_next = sda_s2 ? rrc_pkg::ST_IDLE : rrc_pkg::ST_RDATA;
               end else if (scl_fall) begin
                  // The next byte's first bit must already stand after this fall
                  next_state = ack_next;
                  if (ack_next == rrc_pkg::ST_RDATA) begin
                     next_shreg = rd_byte;
                     next_sda_oe = ~rd_byte[7];
                     next_bit_cnt = 4'h1;
                     next_byte_idx = ~byte_idx;
                  end
               end
            end
            default: begin
               next_state = rrc_pkg::ST_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   // Registers of the serial slave
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= rrc_pkg::ST_IDLE;
         ack_next <= rrc_pkg::ST_IDLE;
         bit_cnt <= rrc_pkg::CNT_RESET;
         shreg <= rrc_pkg::BYTE_RESET;
         ptr <= rrc_pkg::BYTE_RESET;
         hi_byte <= rrc_pkg::BYTE_RESET;
         byte_idx <= 1'b0;
         gen_call <= 1'b0;
         sda_oe <= 1'b0;
         refresh_q <= 1'b0;
         cfg_we_q <= 1'b0;
         cfg_wdata_q <= rrc_pkg::RANGE_CFG_RESET;
         range_cfg <= rrc_pkg::RANGE_CFG_RESET;
      end else begin
         state <= next_state;
         ack_next <= next_ack_next;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         hi_byte <= next_hi_byte;
         byte_idx <= next_byte_idx;
         gen_call <= next_gen_call;
         sda_oe <= next_sda_oe;
         refresh_q <= next_refresh;
         cfg_we_q <= next_cfg_we;
         cfg_wdata_q <= next_cfg_wdata;
         range_cfg <= bank_if.cfg_q; // Registered copy for the analog front end
      end
   end

   rrc_result_bank #(
      .CH(CH),
      .RES_W(RES_W),
      .ACC_W(ACC_W),
      .CNT_W(CNT_W)
   ) u_bank (
      .clk(clk),
      .reset(reset),
      .bus(bank_if.bank),
      .int_accum(int_accum),
      .int_accum_count(int_accum_count),
      .int_bus_voltage(int_bus_voltage),
      .int_sense_voltage(int_sense_voltage),
      .rd_accum(rd_accum),
      .rd_accum_count(rd_accum_count),
      .bus_voltage_result(bus_voltage_result),
      .sense_voltage_result(sense_voltage_result),
      .accum_clear(accum_clear),
      .slow_pin_rise_seen(slow_pin_rise_seen),
      .slow_pin_fall_seen(slow_pin_fall_seen)
   );
endmodule // rrc_refresh_range_config

// ### dv/rrc_host_model.sv
/* Host model of the two-wire bus: start, stop, byte write and byte read.
   Assumes sda has a pull-up and its resolved level comes back on sda. */
`timescale 1ns/1ps
module rrc_host_model (
   input wire logic clk, // System clock
   input wire logic sda, // Resolved sda level
   output logic scl,     // Stands high outside frames
   output logic sda_low  // High while pulling sda low
);
   logic s;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Ten clocks a phase leaves the slave's synchronisers ample margin
   task automatic hp();
      repeat (10) @(posedge clk);
      #2;
   endtask
   // One bit; sda only moves while scl is low
   task automatic bit_io(input logic b, output logic q);
      sda_low = ~b;
      hp();
      scl = 1'b1;
      hp();
      q = sda;
      scl = 1'b0;
      hp();
   endtask
   // Start, also used as repeated start
   task automatic start();
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask
   // Stop leaves both lines released and scl standing high
   task automatic stop();
      sda_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b0;
      hp();
   endtask
   // Write a byte; ack is high when the slave pulled sda low
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   // Read a byte and answer it with ack or not
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack, s);
   endtask
endmodule // rrc_host_model

// ### dv/rrc_props.sv
/* Checker on the top ports of the refresh and range configuration block.
   Assumes scl phases last many clocks. */
`timescale 1ns/1ps
module rrc_props #(
   parameter int CH = 4,
   parameter int ACC_W = 56,
   parameter int CNT_W = 32
) (
   input wire logic clk, // Clock
   input wire logic reset, // Reset, high
   input wire logic scl_in, // Serial clock
   input wire logic slow_pin, // Slow pin
   input wire logic sda_oe, // Pulls sda low
   input wire logic [CH*ACC_W-1:0] int_accum, // Internal sums
   input wire logic [CNT_W-1:0] int_accum_count, // Internal count
   input wire logic [CH*ACC_W-1:0] rd_accum, // Readable sums
   input wire logic [CNT_W-1:0] rd_accum_count, // Readable count
   input wire logic accum_clear, // Clear pulse
   input wire logic [15:0] range_cfg, // Range register
   input wire logic slow_pin_rise_seen, // Rise flag
   input wire logic slow_pin_fall_seen // Fall flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_clear_pulse: assert property (accum_clear |=> !accum_clear)
      else $error("clear pulse too long");
   a_snap_load: assert property (accum_clear |->
      rd_accum == $past(int_accum) && rd_accum_count == $past(int_accum_count))
      else $error("snapshot not loaded");
   // Copies may only move together with the clear pulse
   a_snap_hold: assert property (!accum_clear |-> $stable(rd_accum) && $stable(rd_accum_count))
      else $error("snapshot moved");
   a_flag_clear: assert property ($fell(slow_pin_rise_seen) || $fell(slow_pin_fall_seen) |-> accum_clear)
      else $error("flag dropped without refresh");
   a_refresh_flags: assert property ((!accum_clear && $stable(slow_pin))[*8] ##1 accum_clear |->
      !slow_pin_rise_seen && !slow_pin_fall_seen)
      else $error("flags kept over refresh");
   a_rise_seen: assert property ($rose(slow_pin) |-> ##[1:6] slow_pin_rise_seen)
      else $error("rise not latched");
   a_clear_acked: assert property (accum_clear |-> sda_oe && !scl_in)
      else $error("refresh without ack");
   a_cfg_scl_low: assert property ($changed(range_cfg) |-> !scl_in)
      else $error("range moved while scl high");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda moved while scl high");
   c_refresh: cover property (accum_clear);
   c_cfg: cover property ($changed(range_cfg));
   c_flag: cover property ($fell(slow_pin_fall_seen));
endmodule // rrc_props
bind rrc_refresh_range_config rrc_props #(.CH(CH), .ACC_W(ACC_W), .CNT_W(CNT_W)) i_props (.clk(clk), .reset(reset),
   .scl_in(scl_in), .slow_pin(slow_pin), .sda_oe(sda_oe), .int_accum(int_accum), .int_accum_count(int_accum_count),
   .rd_accum(rd_accum), .rd_accum_count(rd_accum_count), .accum_clear(accum_clear), .range_cfg(range_cfg),
   .slow_pin_rise_seen(slow_pin_rise_seen), .slow_pin_fall_seen(slow_pin_fall_seen));

// ### dv/refresh_and_range_config_tb.sv
/* Bench: a table of range register writes, then the refresh cases.
   Assumes the host model on the pins and a pull-up on sda. */
`timescale 1ns/1ps
module refresh_and_range_config_tb;
   localparam logic [6:0] DEV = 7'h10;
   localparam logic [7:0] REF_CMD = 8'h00;
   localparam logic [7:0] GC_W = {rrc_pkg::GENERAL_CALL_ADDR, 1'b0};
   typedef struct {
      logic [7:0] cmd;
      logic [15:0] wr;
      logic ack;
      logic [15:0] cfg;
   } rrc_row_t;
   // The 0x21 row is an unmapped pointer: refused, register unchanged
   rrc_row_t rows [5] = '{'{8'h20, 16'h4000, 1'b1, 16'h4000}, '{8'h20, 16'h0001, 1'b1, 16'h0001},
      '{8'h20, 16'h5555, 1'b1, 16'h5555}, '{8'h21, 16'hffff, 1'b0, 16'h5555}, '{8'h20, 16'h0000, 1'b1, 16'h0000}};
   logic clk, reset, slow_pin, sda_out, sda_oe, accum_clear, rise, fall, ack, scl, sda_low;
   wire logic sda_in;
   logic [223:0] acc, rd_acc;
   logic [31:0] cnt, rd_cnt;
   logic [63:0] vb, vs, vb_q, vs_q;
   logic [15:0] range_cfg, rd16;
   int n_mismatch = 0;
   int checks = 0;
   int n_clr = 0;
   int cyc = 0;
   // Open drain: low if either side pulls, else the pull-up wins
   assign sda_in = ~(sda_low | sda_oe);
   rrc_host_model i_host (.clk(clk), .sda(sda_in), .scl(scl), .sda_low(sda_low));
   rrc_refresh_range_config #(.DEV_ADDR(DEV), .REFRESH_CMD(REF_CMD)) i_dut (.clk(clk), .reset(reset),
      .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .slow_pin(slow_pin), .int_accum(acc),
      .int_accum_count(cnt), .int_bus_voltage(vb), .int_sense_voltage(vs),
      .rd_accum(rd_acc), .rd_accum_count(rd_cnt),
      .bus_voltage_result(vb_q), .sense_voltage_result(vs_q), .accum_clear(accum_clear), .range_cfg(range_cfg),
      .slow_pin_rise_seen(rise), .slow_pin_fall_seen(fall));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Count clear pulses; the ceiling allows the 1 ms wait with room
   always @(posedge clk) begin
      cyc++;
      if (accum_clear === 1'b1) n_clr++;
      if (cyc == 90000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic chk(input logic [223:0] seen, input logic [223:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Internal values and their expected copies follow one byte pattern
   task automatic fill(input logic [7:0] k);
      acc = {28{k}};
      cnt = {4{k}};
      vb = {8{k}};
      vs = {8{~k}};
   endtask
   task automatic snap(input logic [7:0] k);
      chk(rd_acc, {28{k}});
      chk(rd_cnt, {4{k}});
      chk(vb_q, {8{k}});
      chk(vs_q, {8{~k}});
   endtask
   // Start, address byte, command byte; ack keeps the command's answer
   task automatic send(input logic [7:0] a, input logic [7:0] c);
      i_host.start();
      i_host.wr_byte(a, ack);
      i_host.wr_byte(c, ack);
   endtask
   initial begin
      reset = 1'b1;
      slow_pin = 1'b0;
      fill(8'h00);
      tick(4);
      reset = 1'b0;
      tick(5);
      chk(range_cfg, rrc_pkg::RANGE_CFG_RESET);
      chk({sda_out, rise, fall, accum_clear, rd_cnt}, 36'h0);
      foreach (rows[i]) begin
         send({DEV, 1'b0}, rows[i].cmd);
         i_host.wr_byte(rows[i].wr[15:8], ack);
         chk(ack, rows[i].ack);
         i_host.wr_byte(rows[i].wr[7:0], ack);
         send({DEV, 1'b0}, rrc_pkg::REG_RANGE_CFG);
         i_host.start();
         i_host.wr_byte({DEV, 1'b1}, ack);
         i_host.rd_byte(1'b1, rd16[15:8]);
         i_host.rd_byte(1'b0, rd16[7:0]);
         i_host.stop();
         chk(range_cfg, rows[i].cfg);
         chk(rd16, rows[i].cfg);
      end
      // Both slow pin edges latch, then a general-call refresh clears them
      slow_pin = 1'b1;
      tick(10);
      slow_pin = 1'b0;
      tick(10);
      chk({rise, fall}, 2'b11);
      fill(8'ha5);
      send(GC_W, rrc_pkg::CMD_GC_REFRESH);
      chk(ack, 1'b1);
      i_host.stop();
      chk(n_clr, 1);
      snap(8'ha5);
      chk({rise, fall}, 2'b00);
      // Copies must not follow the internal values before the next refresh
      fill(8'h3c);
      tick(rrc_pkg::REFRESH_SETTLE_CYC);
      snap(8'ha5);
      // A data byte after the command is refused
      send(GC_W, rrc_pkg::CMD_GC_REFRESH);
      i_host.wr_byte(8'h77, ack);
      chk(ack, 1'b0);
      i_host.stop();
      chk(n_clr, 2);
      snap(8'h3c);
      // Another general-call command and a general-call read do nothing
      send(GC_W, rrc_pkg::REG_RANGE_CFG);
      chk(ack, 1'b0);
      i_host.start();
      i_host.wr_byte(8'h01, ack);
      chk(ack, 1'b0);
      i_host.stop();
      // The ordinary refresh acts the same way, slow pin flags included
      slow_pin = 1'b1;
      tick(10);
      chk({rise, fall}, 2'b10);
      fill(8'h96);
      send({DEV, 1'b0}, REF_CMD);
      chk(ack, 1'b1);
      i_host.stop();
      chk(n_clr, 3);
      snap(8'h96);
      chk({rise, fall}, 2'b00);
      // Reset in mid-run; the slow pin stays high, so its flags are left out
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick(5);
      chk({sda_oe, accum_clear, rd_cnt, range_cfg}, 50'h0);
      results();
   end
endmodule // refresh_and_range_config_tb
